// ---- core/afs_pkg.sv ----
// Function
// - Undervoltage shuts the whole system down; restart 100 ms after recovery.
// - Overvoltage shuts power stages down; restart 100 ms after recovery.
// - Unbalance fault when either supply magnitude exceeds twice the other.
// - After unbalance clears, restart once 100 ms has elapsed.
// - Lost or slow external clock switches amplifier off until it returns.
// - After clock loss, the 100 ms delay starts only once clock is back.
// - Foldback only reduces gain; warning asserts first; status output stays idle.
// - Overcurrent shuts down only with low-impedance short; else limits; timer pin.
// - Window check at start-up and restarts holds start-up, restarts directly.
// - Overtemp and supply and clock faults: shutdown, 100 ms restart, status.
// - Status pulses at switching rate while limiting; steady after shutdown.
// - Shutdown shows a status pulse of about 100 ms; start-up shows status only during the window check.
// - Disabling foldback never disables the thermal warning output.
// - Persistent overcurrent shutdown retries switching every 100 ms.
package afs_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int SUPPLY_W = 12;

  // =========================================================
  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATE_OFS = 4'h4;
  localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFS = 4'hc;

  // =========================================================
  // Control fields and reset value
  localparam int CTRL_OPERATE_BIT = 0;
  localparam int CTRL_FOLD_DIS_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // =========================================================
  // Fault and event bit positions (live state, status and mask)
  localparam int FLT_W = 9;
  localparam int FLT_UNDER = 0;
  localparam int FLT_OVER = 1;
  localparam int FLT_UNBAL = 2;
  localparam int FLT_CLOCK = 3;
  localparam int FLT_OTEMP = 4;
  localparam int FLT_LIMIT = 5;
  localparam int FLT_SHORT = 6;
  localparam int FLT_WINDOW = 7;
  localparam int FLT_WARN = 8;
  localparam int STATE_FIELD_LSB = 16;
  localparam logic [FLT_W-1:0] MASK_RESET = 9'h000;

  // =========================================================
  // Timing
  localparam int CLK_HZ = 250_000_000;
  localparam int RESTART_MS = 100;
  localparam int RESTART_CYC = RESTART_MS * (CLK_HZ / 1000);
  localparam int CLK_LOSS_CYC = 1024;

  typedef enum logic [2:0] {
    AFS_STBY,
    AFS_CHECK,
    AFS_RUN,
    AFS_OFF,
    AFS_DELAY
  } afs_state_t;

endpackage

// ---- core/afs_supervisor.sv ----
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module afs_supervisor #(
  parameter int RESTART_CYC = afs_pkg::RESTART_CYC,
  parameter int CLK_LOSS_CYC = afs_pkg::CLK_LOSS_CYC,
  parameter int SUPPLY_W = afs_pkg::SUPPLY_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [afs_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [afs_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [afs_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  input wire logic undervoltage_i,
  input wire logic overvoltage_i,
  input wire logic overtemp_i,
  input wire logic temp_warn_i,
  input wire logic fold_temp_i,
  input wire logic overcurrent_fault_i,
  input wire logic short_below_threshold_i,
  input wire logic window_fault_i,
  input wire logic ext_osc_i,
  input wire logic pwm_phase_i,
  input wire logic [SUPPLY_W-1:0] positive_analog_supply_i,
  input wire logic [SUPPLY_W-1:0] negative_analog_supply_i,
  output logic power_stage_en_o,
  output logic system_shutdown_o,
  output logic thermal_foldback_o,
  output logic thermal_warning_out_o,
  output logic protection_status_out_o,
  output logic short_timer_active_o
);

  // =========================================================
  // Reset release
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // =========================================================
  // Input synchronisers
  localparam int PIN_W = 10;
  localparam int SUP2_W = 2 * SUPPLY_W;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_s;
  logic [SUP2_W-1:0] sup_meta;
  logic [SUP2_W-1:0] sup_s;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_s <= '0;
    end else begin
      pin_meta <= {pwm_phase_i, ext_osc_i, window_fault_i,
                   short_below_threshold_i, overcurrent_fault_i,
                   fold_temp_i, temp_warn_i, overtemp_i,
                   overvoltage_i, undervoltage_i};
      pin_s <= pin_meta;
    end
  end

  // Supply codes change slowly against the clock, so a word-wide
  // two-stage capture is accepted; a torn sample lasts one cycle.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sup_meta <= '0;
      sup_s <= '0;
    end else begin
      sup_meta <= {positive_analog_supply_i, negative_analog_supply_i};
      sup_s <= sup_meta;
    end
  end

  logic uv_s;
  logic ov_s;
  logic ot_s;
  logic warn_s;
  logic fold_s;
  logic oc_s;
  logic lowz_s;
  logic win_s;
  logic osc_s;
  logic phase_s;
  logic [SUPPLY_W-1:0] vpos;
  logic [SUPPLY_W-1:0] vneg;

  assign {phase_s, osc_s, win_s, lowz_s, oc_s,
          fold_s, warn_s, ot_s, ov_s, uv_s} = pin_s;
  assign vpos = sup_s[SUP2_W-1:SUPPLY_W];
  assign vneg = sup_s[SUPPLY_W-1:0];

  // =========================================================
  // Supply unbalance
  function automatic logic above_twice(
    input logic [SUPPLY_W-1:0] a,
    input logic [SUPPLY_W-1:0] b
  );
    above_twice = {1'b0, a} > {b, 1'b0};
  endfunction

  logic unbal;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      unbal <= 1'b0;
    end else begin
      unbal <= above_twice(vpos, vneg) | above_twice(vneg, vpos);
    end
  end

  // =========================================================
  // External clock watchdog
  localparam int OSC_W = $clog2(CLK_LOSS_CYC + 1);
  localparam logic [OSC_W-1:0] OSC_LIMIT = OSC_W'(CLK_LOSS_CYC);
  logic osc_q;
  logic [OSC_W-1:0] osc_cnt;
  logic clk_lost;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_q <= 1'b0;
      osc_cnt <= '0;
    end else begin
      osc_q <= osc_s;
      if (osc_s != osc_q) begin
        osc_cnt <= '0;
      end else if (osc_cnt != OSC_LIMIT) begin
        osc_cnt <= osc_cnt + 1'b1;
      end
    end
  end

  // A clock too slow to toggle within the window counts as lost
  assign clk_lost = (osc_cnt == OSC_LIMIT);

  // =========================================================
  // Fault summary
  logic oc_short;
  logic shut_any;
  logic [afs_pkg::FLT_W-1:0] faults;

  assign oc_short = oc_s & lowz_s;
  assign shut_any = uv_s | ov_s | unbal | clk_lost | ot_s
                  | oc_short;

  always_comb begin
    faults = '0;
    faults[afs_pkg::FLT_UNDER] = uv_s;
    faults[afs_pkg::FLT_OVER] = ov_s;
    faults[afs_pkg::FLT_UNBAL] = unbal;
    faults[afs_pkg::FLT_CLOCK] = clk_lost;
    faults[afs_pkg::FLT_OTEMP] = ot_s;
    faults[afs_pkg::FLT_LIMIT] = oc_s & ~lowz_s;
    faults[afs_pkg::FLT_SHORT] = oc_short;
    faults[afs_pkg::FLT_WINDOW] = win_s;
    faults[afs_pkg::FLT_WARN] = warn_s;
  end

  // =========================================================
  // Control register
  logic [1:0] ctrl;
  logic operate;
  logic fold_dis;

  assign operate = ctrl[afs_pkg::CTRL_OPERATE_BIT];
  assign fold_dis = ctrl[afs_pkg::CTRL_FOLD_DIS_BIT];

  // =========================================================
  // Protection sequencer
  localparam int DLY_W = $clog2(RESTART_CYC + 1);
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(RESTART_CYC - 1);
  afs_pkg::afs_state_t state;
  afs_pkg::afs_state_t next_state;
  logic [DLY_W-1:0] dly_cnt;

  always_comb begin
    next_state = state;
    unique case (state)
      afs_pkg::AFS_STBY: begin
        if (shut_any) begin
          next_state = afs_pkg::AFS_OFF;
        end else if (operate) begin
          next_state = afs_pkg::AFS_CHECK;
        end
      end
      afs_pkg::AFS_CHECK: begin
        if (shut_any) begin
          next_state = afs_pkg::AFS_OFF;
        end else if (!operate) begin
          next_state = afs_pkg::AFS_STBY;
        end else if (!win_s) begin
          next_state = afs_pkg::AFS_RUN;
        end
      end
      afs_pkg::AFS_RUN: begin
        if (shut_any) begin
          next_state = afs_pkg::AFS_OFF;
        end else if (!operate) begin
          next_state = afs_pkg::AFS_STBY;
        end
      end
      afs_pkg::AFS_OFF: begin
        if (!shut_any) begin
          next_state = afs_pkg::AFS_DELAY;
        end
      end
      afs_pkg::AFS_DELAY: begin
        if (shut_any) begin
          next_state = afs_pkg::AFS_OFF;
        end else if (dly_cnt == DLY_LAST) begin
          // Every restart, also after a short, passes the window check
          next_state = afs_pkg::AFS_CHECK;
        end
      end
      default: next_state = afs_pkg::AFS_STBY;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= afs_pkg::AFS_STBY;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dly_cnt <= '0;
    end else if (state == afs_pkg::AFS_DELAY) begin
      dly_cnt <= dly_cnt + 1'b1;
    end else begin
      dly_cnt <= '0;
    end
  end

  // =========================================================
  // Outputs to the power stage and diagnostic pins
  logic status_next;

  // Decoded from next_state so status and stage enable move at one edge;
  // otherwise the first switching cycle would still show the start pulse
  always_comb begin
    unique case (next_state)
      afs_pkg::AFS_RUN: status_next = oc_s & phase_s;
      afs_pkg::AFS_OFF,
      afs_pkg::AFS_DELAY,
      afs_pkg::AFS_CHECK: status_next = 1'b1;
      default: status_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      power_stage_en_o <= 1'b0;
      system_shutdown_o <= 1'b0;
      protection_status_out_o <= 1'b0;
      short_timer_active_o <= 1'b0;
    end else begin
      power_stage_en_o <= (next_state == afs_pkg::AFS_RUN);
      system_shutdown_o <= uv_s;
      protection_status_out_o <= status_next;
      short_timer_active_o <= oc_s &
                              (state == afs_pkg::AFS_RUN);
    end
  end

  // Foldback and warning touch neither the sequencer nor status output
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      thermal_foldback_o <= 1'b0;
      thermal_warning_out_o <= 1'b0;
    end else begin
      thermal_foldback_o <= fold_s & ~fold_dis;
      thermal_warning_out_o <= warn_s;
    end
  end

  // =========================================================
  // Register bus slave
  logic ack;
  logic wr_en;
  logic [afs_pkg::FLT_W-1:0] irq_stat;
  logic [afs_pkg::FLT_W-1:0] irq_mask;
  logic [afs_pkg::FLT_W-1:0] faults_q;
  logic [afs_pkg::FLT_W-1:0] w1c;

  // Every access answers one edge after it is seen
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign wr_en = avs_write_i & ~ack;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_i | avs_write_i) & ~ack;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= afs_pkg::CTRL_RESET;
    end else if (wr_en && avs_address_i == afs_pkg::CTRL_OFS
                 && avs_byteenable_i[0]) begin
      ctrl <= avs_writedata_i[1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= afs_pkg::MASK_RESET;
    end else if (wr_en && avs_address_i == afs_pkg::IRQ_MASK_OFS) begin
      if (avs_byteenable_i[0]) begin
        irq_mask[7:0] <= avs_writedata_i[7:0];
      end
      if (avs_byteenable_i[1]) begin
        irq_mask[8] <= avs_writedata_i[8];
      end
    end
  end

  always_comb begin
    w1c = '0;
    if (wr_en && avs_address_i == afs_pkg::IRQ_STAT_OFS) begin
      if (avs_byteenable_i[0]) begin
        w1c[7:0] = avs_writedata_i[7:0];
      end
      if (avs_byteenable_i[1]) begin
        w1c[8] = avs_writedata_i[8];
      end
    end
  end

  // A new rising fault in the clearing cycle stays set
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      faults_q <= '0;
      irq_stat <= '0;
    end else begin
      faults_q <= faults;
      irq_stat <= (irq_stat & ~w1c) | (faults & ~faults_q);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i && !ack) begin
      unique case (avs_address_i)
        afs_pkg::CTRL_OFS:
          avs_readdata_o <= {30'h0, ctrl};
        afs_pkg::STATE_OFS:
          avs_readdata_o <= {13'h0, 3'(state), 7'h0, faults};
        afs_pkg::IRQ_STAT_OFS:
          avs_readdata_o <= {23'h0, irq_stat};
        afs_pkg::IRQ_MASK_OFS:
          avs_readdata_o <= {23'h0, irq_mask};
        default: avs_readdata_o <= '0;
      endcase
    end
  end

endmodule

// ---- dv/afs_stage_model.sv ----
`timescale 1ns/1ps
// Power stage with a load, plus oscillator; current only flows while on
module afs_stage_model (
  input wire logic clk_i,
  input wire logic stage_en_i,
  input wire logic short_load_i,
  input wire logic limit_load_i,
  input wire logic osc_run_i,
  output logic overcurrent_o,
  output logic low_z_o,
  output logic ext_osc_o,
  output logic pwm_phase_o
);
  initial begin
    overcurrent_o = 1'b0;
    low_z_o = 1'b0;
    ext_osc_o = 1'b0;
    pwm_phase_o = 1'b0;
  end
  always @(posedge clk_i) begin
    pwm_phase_o <= ~pwm_phase_o;
    if (osc_run_i) begin
      ext_osc_o <= ~ext_osc_o;
    end
    overcurrent_o <= stage_en_i & (short_load_i | limit_load_i);
    low_z_o <= stage_en_i & short_load_i;
  end
endmodule

// ---- dv/afs_supervisor_asserts.sv ----
`timescale 1ns/1ps
module afs_supervisor_asserts #(
  parameter int RESTART_CYC = 50
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic undervoltage_i,
  input wire logic overvoltage_i,
  input wire logic overtemp_i,
  input wire logic temp_warn_i,
  input wire logic fold_temp_i,
  input wire logic overcurrent_fault_i,
  input wire logic short_below_threshold_i,
  input wire logic power_stage_en_o,
  input wire logic thermal_foldback_o,
  input wire logic thermal_warning_out_o,
  input wire logic protection_status_out_o,
  input wire logic short_timer_active_o
);
  logic [3:0] up;
  int quiet;
  logic shut;
  assign shut = undervoltage_i | overvoltage_i | overtemp_i |
    (overcurrent_fault_i & short_below_threshold_i);
  // Checks wait until the reset and input synchronisers have settled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up <= 4'h0;
    end else if (up != 4'hf) begin
      up <= up + 4'h1;
    end
  end
  // Starts full so that the first start-up needs no delay
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiet <= RESTART_CYC;
    end else if (shut) begin
      quiet <= 0;
    end else if (quiet < RESTART_CYC) begin
      quiet <= quiet + 1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i || up != 4'hf);
  // ==========================================================
  // Properties
  a_bus_one_wait: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("bus late");
  a_supply_stop: assert property (
    (undervoltage_i || overvoltage_i || overtemp_i) [*5]
    |-> !power_stage_en_o) else $error("stage on in fault");
  a_short_stop: assert property (
    $rose(overcurrent_fault_i && short_below_threshold_i)
    |-> ##[1:6] !power_stage_en_o) else $error("short not stopped");
  a_restart_delay: assert property (
    $rose(power_stage_en_o) |-> quiet >= RESTART_CYC)
    else $error("restart too early");
  a_fall_status: assert property (
    $fell(power_stage_en_o) && $past(shut, 3)
    |-> protection_status_out_o) else $error("no shutdown status");
  a_run_quiet: assert property (
    (!overcurrent_fault_i) [*5] ##0 power_stage_en_o
    |-> !protection_status_out_o) else $error("status in clean run");
  a_warn_follow: assert property (
    temp_warn_i [*5] |-> thermal_warning_out_o) else $error("no warning");
  a_fold_idle: assert property (
    (!fold_temp_i) [*5] |-> !thermal_foldback_o) else $error("stray fold");
  a_timer_idle: assert property (
    (!overcurrent_fault_i) [*5] |-> !short_timer_active_o)
    else $error("stray timer");
  c_restart: cover property ($rose(power_stage_en_o));
  c_limit: cover property (short_timer_active_o && protection_status_out_o);
  c_warn: cover property (thermal_warning_out_o && !thermal_foldback_o);
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  localparam int RC = 50;
  logic clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
  logic [3:0] avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic undervoltage_i, overvoltage_i, overtemp_i, temp_warn_i, fold_temp_i;
  logic overcurrent_fault_i, short_below_threshold_i, window_fault_i;
  logic ext_osc_i, pwm_phase_i, osc_run, short_load, limit_load, prev;
  logic [11:0] positive_analog_supply_i, negative_analog_supply_i;
  logic power_stage_en_o, system_shutdown_o, thermal_foldback_o;
  logic thermal_warning_out_o, protection_status_out_o, short_timer_active_o;
  int mismatches, n_checks, waited, rises;
  afs_supervisor #(.RESTART_CYC(RC), .CLK_LOSS_CYC(16)) u_afs_supervisor (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_o(irq_o), .undervoltage_i(undervoltage_i),
    .overvoltage_i(overvoltage_i), .overtemp_i(overtemp_i),
    .temp_warn_i(temp_warn_i), .fold_temp_i(fold_temp_i),
    .overcurrent_fault_i(overcurrent_fault_i),
    .short_below_threshold_i(short_below_threshold_i),
    .window_fault_i(window_fault_i), .ext_osc_i(ext_osc_i),
    .pwm_phase_i(pwm_phase_i),
    .positive_analog_supply_i(positive_analog_supply_i),
    .negative_analog_supply_i(negative_analog_supply_i),
    .power_stage_en_o(power_stage_en_o),
    .system_shutdown_o(system_shutdown_o),
    .thermal_foldback_o(thermal_foldback_o),
    .thermal_warning_out_o(thermal_warning_out_o),
    .protection_status_out_o(protection_status_out_o),
    .short_timer_active_o(short_timer_active_o));
  afs_stage_model u_afs_stage_model (.clk_i(clk_i),
    .stage_en_i(power_stage_en_o), .short_load_i(short_load),
    .limit_load_i(limit_load), .osc_run_i(osc_run),
    .overcurrent_o(overcurrent_fault_i), .low_z_o(short_below_threshold_i),
    .ext_osc_o(ext_osc_i), .pwm_phase_o(pwm_phase_i));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // ==========================================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic stop_test();
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chkb("bus_answer", 1'b1, n < 20);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic wait_en(input logic v, input int lim);
    waited = 0;
    while (power_stage_en_o !== v && waited < lim) begin
      @(posedge clk_i);
      waited++;
    end
  endtask
  task automatic set_fault(input int k, input logic v);
    case (k)
      0: undervoltage_i <= v;
      1: overvoltage_i <= v;
      2: overtemp_i <= v;
      3: positive_analog_supply_i <= v ? 12'h300 : 12'h100;
      4: osc_run <= !v;
      default: negative_analog_supply_i <= v ? 12'h201 : 12'h100;
    endcase
  endtask
  // ==========================================================
  // Sequence
  initial begin
    {rst_n_i, avs_read_i, avs_write_i, undervoltage_i, overvoltage_i} = '0;
    {overtemp_i, temp_warn_i, fold_temp_i, short_load, limit_load} = '0;
    {avs_address_i, avs_writedata_i, prev, mismatches, n_checks} = '0;
    {positive_analog_supply_i, negative_analog_supply_i} = {2{12'h100}};
    avs_byteenable_i = 4'hf;
    osc_run = 1'b1;
    window_fault_i = 1'b1;
    cyc(5);
    rst_n_i <= 1'b1;
    cyc(3);
    bus(1'b0, afs_pkg::CTRL_OFS, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    bus(1'b0, afs_pkg::IRQ_MASK_OFS, 32'h0);
    chk("mask_reset", 32'h0, rd);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, afs_pkg::CTRL_OFS, 32'h1);
    cyc(10);
    chkb("start_held", 1'b0, power_stage_en_o);
    chkb("start_status", 1'b1, protection_status_out_o);
    window_fault_i <= 1'b0;
    wait_en(1'b1, 12);
    chkb("start_direct", 1'b1, power_stage_en_o);
    positive_analog_supply_i <= 12'h200;
    cyc(8);
    chkb("unbal_edge", 1'b1, power_stage_en_o);
    for (int k = 0; k < 6; k++) begin
      set_fault(k, 1'b1);
      wait_en(1'b0, 40);
      chkb("fault_stop", 1'b0, power_stage_en_o);
      chkb("fault_status", 1'b1, protection_status_out_o);
      chkb("fault_warn", 1'b0, thermal_warning_out_o);
      chkb("fault_timer", 1'b0, short_timer_active_o);
      chkb("fault_sys", k == 0, system_shutdown_o);
      cyc(RC);
      chkb("fault_hold", 1'b0, power_stage_en_o);
      set_fault(k, 1'b0);
      wait_en(1'b1, 3 * RC);
      chkb("restart", 1'b1, waited >= RC && power_stage_en_o);
    end
    set_fault(0, 1'b1);
    set_fault(1, 1'b1);
    wait_en(1'b0, 40);
    set_fault(0, 1'b0);
    cyc(RC + 10);
    chkb("multi_hold", 1'b0, power_stage_en_o);
    set_fault(1, 1'b0);
    wait_en(1'b1, 3 * RC);
    chkb("multi_gap", 1'b1, waited >= RC && power_stage_en_o);
    limit_load <= 1'b1;
    cyc(8);
    chkb("limit_run", 1'b1, power_stage_en_o);
    chkb("limit_timer", 1'b1, short_timer_active_o);
    rises = 0;
    repeat (4) begin
      @(posedge clk_i);
      rises += protection_status_out_o ? 1 : 0;
    end
    chkb("limit_pulse", 1'b1, rises inside {[1:3]});
    limit_load <= 1'b0;
    short_load <= 1'b1;
    wait_en(1'b0, 20);
    chkb("short_stop", 1'b0, power_stage_en_o);
    chkb("short_status", 1'b1, protection_status_out_o);
    rises = 0;
    repeat (3 * RC + 40) begin
      @(posedge clk_i);
      if (power_stage_en_o === 1'b1 && !prev) rises++;
      prev = power_stage_en_o;
    end
    chkb("retries", 1'b1, rises >= 2);
    // Catch a retry as it starts, so the delay is still far from its end
    wait_en(1'b1, 2 * RC);
    wait_en(1'b0, 20);
    window_fault_i <= 1'b1;
    short_load <= 1'b0;
    cyc(2 * RC + 20);
    chkb("window_hold", 1'b0, power_stage_en_o);
    chkb("window_status", 1'b1, protection_status_out_o);
    window_fault_i <= 1'b0;
    wait_en(1'b1, 3 * RC);
    chkb("window_direct", 1'b1, waited < 10);
    bus(1'b1, afs_pkg::CTRL_OFS, 32'h3);
    fold_temp_i <= 1'b1;
    temp_warn_i <= 1'b1;
    cyc(6);
    chkb("fold_off", 1'b0, thermal_foldback_o);
    chkb("warn_kept", 1'b1, thermal_warning_out_o);
    chkb("fold_run", 1'b1,
         power_stage_en_o && !protection_status_out_o);
    bus(1'b1, afs_pkg::CTRL_OFS, 32'h1);
    cyc(6);
    chkb("fold_on", 1'b1, thermal_foldback_o);
    fold_temp_i <= 1'b0;
    temp_warn_i <= 1'b0;
    bus(1'b1, afs_pkg::IRQ_STAT_OFS, 32'h1ff);
    bus(1'b1, afs_pkg::IRQ_MASK_OFS, 32'h2);
    cyc(3);
    chkb("irq_idle", 1'b0, irq_o);
    set_fault(1, 1'b1);
    wait_en(1'b0, 40);
    cyc(3);
    chkb("irq_set", 1'b1, irq_o);
    bus(1'b0, afs_pkg::STATE_OFS, 32'h0);
    chk("state_off", 32'h0003_0002, rd & 32'h0007_0002);
    bus(1'b1, afs_pkg::IRQ_MASK_OFS, 32'h0);
    cyc(3);
    chkb("irq_masked", 1'b0, irq_o);
    set_fault(1, 1'b0);
    bus(1'b1, afs_pkg::IRQ_STAT_OFS, 32'h2);
    bus(1'b1, afs_pkg::IRQ_MASK_OFS, 32'h2);
    cyc(3);
    chkb("irq_clear", 1'b0, irq_o);
    stop_test();
  end
  initial begin
    cyc(20000);
    mismatches++;
    stop_test();
  end
endmodule
bind afs_supervisor afs_supervisor_asserts #(.RESTART_CYC(RESTART_CYC))
  u_afs_supervisor_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .undervoltage_i(undervoltage_i),
  .overvoltage_i(overvoltage_i), .overtemp_i(overtemp_i),
  .temp_warn_i(temp_warn_i), .fold_temp_i(fold_temp_i),
  .overcurrent_fault_i(overcurrent_fault_i),
  .short_below_threshold_i(short_below_threshold_i),
  .power_stage_en_o(power_stage_en_o),
  .thermal_foldback_o(thermal_foldback_o),
  .thermal_warning_out_o(thermal_warning_out_o),
  .protection_status_out_o(protection_status_out_o),
  .short_timer_active_o(short_timer_active_o));
